// File: rtl/render_attribute_pixel_gate.sv
// Per-pixel rendering attribute gate with an AXI4-Lite register port.
// Assumes commands and pixels arrive from logic on mclk, one pixel stream.
//
// What this block does
// - Transparent binary: skip zero, foreground on one
// - Opaque binary: background on zero, foreground one
// - Transparent multi-valued: all-zero source pixel skipped
// - Tile bit: repeat source, else scale it
// - Region select 0: user_region_select to system rectangle
// - Region select 1: user rectangle only
// - User_region_select bounds are inclusive
// - Net drawing: write when x+y parity matches, except work strokes and trap fills
// - Parity bit qualifies net and half sampling
// - Work strokes write parity bit into work
// - Half sampling: every other source pixel, binary quad
// - Work masking: write only where work bit set
// - Masking for quads only; textured strokes ignore
// - Independent thicken per side, double gives two
// - Parallel copies per segment, stroke commands only
// - Linear source address, multi-valued quad only
// - Two-pixel mode: pairs, region select only
`timescale 1ns/1ps
`include "render_attr_map.svh"

module render_attribute_pixel_gate (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Command load
  input wire logic cmd_load,
  input wire logic [4:0] cmd_code,
  input wire logic [`ATTR_W-1:0] cmd_attr,
  // Command configuration for the engines
  output logic tile_repeat_enable,
  output logic half_sample_enable,
  output logic half_sample_phase,
  output logic linear_source_address,
  output logic two_pixel_mode,
  output logic [1:0] extra_up_left,
  output logic [1:0] extra_down_right,
  output logic [2:0] line_width,
  // Pixel input
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic signed [`COORD_W-1:0] pix_x,
  input wire logic signed [`COORD_W-1:0] pix_y,
  input wire logic pix_src_bit,
  input wire logic [15:0] pix_src_data,
  input wire logic [15:0] pix_src_data_odd,
  input wire logic pix_work_bit,
  // Pixel output
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_write,
  output logic out_to_work,
  output logic signed [`COORD_W-1:0] out_x,
  output logic signed [`COORD_W-1:0] out_y,
  output logic [15:0] out_colour,
  output logic [15:0] out_colour_odd
);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [`COORD_W-1:0] sys_min_x_r, sys_min_y_r, sys_max_x_r, sys_max_y_r;
  logic [`COORD_W-1:0] usr_min_x_r, usr_min_y_r, usr_max_x_r, usr_max_y_r;
  logic [15:0] bg_colour_r, fg_colour_r, wr_count_r, skip_count_r;
  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [31:0] wmask, rd_word, wr_old, wr_word;
  logic wr_go, rd_go, rd_hit, wr_hit, count_clear;

  always_comb begin
    wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    rd_go = s_axi_arvalid && !rvalid_r;
    wr_hit = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr <= `REG_CONTROL);
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `REG_SYS_MIN: rd_word = {5'h00, sys_min_y_r, 5'h00, sys_min_x_r};
      `REG_SYS_MAX: rd_word = {5'h00, sys_max_y_r, 5'h00, sys_max_x_r};
      `REG_USR_MIN: rd_word = {5'h00, usr_min_y_r, 5'h00, usr_min_x_r};
      `REG_USR_MAX: rd_word = {5'h00, usr_max_y_r, 5'h00, usr_max_x_r};
      `REG_BG_COLOUR: rd_word = {16'h0000, bg_colour_r};
      `REG_FG_COLOUR: rd_word = {16'h0000, fg_colour_r};
      `REG_STATUS: rd_word = {skip_count_r, wr_count_r};
      `REG_CONTROL: rd_word = 32'h0000_0000;
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    case (s_axi_awaddr)
      `REG_SYS_MIN: wr_old = {5'h00, sys_min_y_r, 5'h00, sys_min_x_r};
      `REG_SYS_MAX: wr_old = {5'h00, sys_max_y_r, 5'h00, sys_max_x_r};
      `REG_USR_MIN: wr_old = {5'h00, usr_min_y_r, 5'h00, usr_min_x_r};
      `REG_USR_MAX: wr_old = {5'h00, usr_max_y_r, 5'h00, usr_max_x_r};
      `REG_BG_COLOUR: wr_old = {16'h0000, bg_colour_r};
      `REG_FG_COLOUR: wr_old = {16'h0000, fg_colour_r};
      default: wr_old = 32'h0000_0000;
    endcase
    wr_word = (wr_old & ~wmask) | (s_axi_wdata & wmask);
    count_clear = wr_go && (s_axi_awaddr == `REG_CONTROL) &&
                  s_axi_wstrb[0] && s_axi_wdata[0];
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sys_min_x_r <= `MIN_RESET;
      sys_min_y_r <= `MIN_RESET;
      sys_max_x_r <= `MAX_RESET;
      sys_max_y_r <= `MAX_RESET;
      usr_min_x_r <= `MIN_RESET;
      usr_min_y_r <= `MIN_RESET;
      usr_max_x_r <= `MAX_RESET;
      usr_max_y_r <= `MAX_RESET;
      bg_colour_r <= `COLOUR_RESET;
      fg_colour_r <= `COLOUR_RESET;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_awaddr)
          `REG_SYS_MIN: {sys_min_y_r, sys_min_x_r} <=
            {wr_word[26:16], wr_word[10:0]};
          `REG_SYS_MAX: {sys_max_y_r, sys_max_x_r} <=
            {wr_word[26:16], wr_word[10:0]};
          `REG_USR_MIN: {usr_min_y_r, usr_min_x_r} <=
            {wr_word[26:16], wr_word[10:0]};
          `REG_USR_MAX: {usr_max_y_r, usr_max_x_r} <=
            {wr_word[26:16], wr_word[10:0]};
          `REG_BG_COLOUR: bg_colour_r <= wr_word[15:0];
          `REG_FG_COLOUR: fg_colour_r <= wr_word[15:0];
          default: ;
        endcase
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Unsupported attribute bits are trusted to be zero, so decode masks
  // by command where a bit is shared with another meaning, plus tile and two-pixel.
  logic [4:0] code_r, code_nxt;
  logic [`ATTR_W-1:0] attr_r, attr_nxt;
  logic is_quad, is_binary, is_stroke, is_work_stroke, is_trap, is_tex;

  always_comb begin
    code_nxt = cmd_load ? cmd_code : code_r;
    attr_nxt = cmd_load ? cmd_attr : attr_r;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      code_r <= 5'h1F;
      attr_r <= '0;
    end else begin
      code_r <= code_nxt;
      attr_r <= attr_nxt;
    end
  end

  always_comb begin
    is_quad = (code_r == `CMD_QUAD_MULTI) || (code_r == `CMD_QUAD_BINARY) ||
              (code_r == `CMD_QUAD_SOLID);
    is_tex = (code_r == `CMD_TEX_STROKE) || (code_r == `CMD_REL_TEX_STROKE);
    is_binary = (code_r == `CMD_QUAD_BINARY) || is_tex;
    is_stroke = (code_r == `CMD_STROKE) || (code_r == `CMD_REL_STROKE);
    is_work_stroke = (code_r == `CMD_WORK_STROKE) ||
                     (code_r == `CMD_REL_WORK_STROKE);
    is_trap = (code_r == `CMD_TRAP_FILL) || (code_r == `CMD_REL_TRAP_FILL);
  end

  // Engine configuration; tile and half are not checked against each
  // other, since software keeps them apart.
  assign tile_repeat_enable = attr_r[`ATTR_TILE] && (is_quad || is_tex);
  assign half_sample_enable = attr_r[`ATTR_HALF] &&
                              (code_r == `CMD_QUAD_BINARY);
  assign half_sample_phase = attr_r[`ATTR_PARITY];
  assign linear_source_address = attr_r[`ATTR_LINEAR] &&
                                 (code_r == `CMD_QUAD_MULTI);
  assign two_pixel_mode = attr_r[`ATTR_TWO_PIXEL] &&
                          ((code_r == `CMD_QUAD_MULTI) ||
                           (code_r == `CMD_QUAD_SOLID));
  // Each side widens on its own; the line engine repeats the segment once
  // per unit of extra, with no special joint handling.
  assign extra_up_left = !(is_stroke && attr_r[`ATTR_THICK_UL]) ? 2'h0 :
                         (attr_r[`ATTR_DOUBLE_UL] ? 2'h2 : 2'h1);
  assign extra_down_right = !(is_stroke && attr_r[`ATTR_THICK_DR]) ? 2'h0 :
                            (attr_r[`ATTR_DOUBLE_DR] ? 2'h2 : 2'h1);
  assign line_width = 3'h1 + {1'b0, extra_up_left} +
                      {1'b0, extra_down_right};

  // ----------------------------------------------------------------------
  // Pixel gate
  // ----------------------------------------------------------------------
  logic out_valid_r, out_valid_nxt, to_work_r, to_work_nxt;
  logic [1:0] write_r, write_nxt;
  logic signed [`COORD_W-1:0] x_r, x_nxt, y_r, y_nxt;
  logic [15:0] colour_r, colour_nxt, colour_odd_r, colour_odd_nxt;
  logic [15:0] wr_count_nxt, skip_count_nxt;
  logic take, user_region_select_ok, user_region_select_ok_odd, net_ok, work_ok, src_ok;
  logic signed [`COORD_W-1:0] lo_x, lo_y, hi_x, hi_y, x_odd;
  render_attr_pkg::src_kind_t kind;

  assign pix_ready = !out_valid_r || out_ready;
  assign take = pix_valid && pix_ready;

  always_comb begin
    lo_x = attr_r[`ATTR_USER_REGION] ? usr_min_x_r : sys_min_x_r;
    lo_y = attr_r[`ATTR_USER_REGION] ? usr_min_y_r : sys_min_y_r;
    hi_x = attr_r[`ATTR_USER_REGION] ? usr_max_x_r : sys_max_x_r;
    hi_y = attr_r[`ATTR_USER_REGION] ? usr_max_y_r : sys_max_y_r;
    x_odd = pix_x + 11'sh001;
    user_region_select_ok = (pix_x >= lo_x) && (pix_x <= hi_x) &&
              (pix_y >= lo_y) && (pix_y <= hi_y);
    user_region_select_ok_odd = (x_odd >= lo_x) && (x_odd <= hi_x) &&
                  (pix_y >= lo_y) && (pix_y <= hi_y);
    net_ok = !attr_r[`ATTR_NET] || is_work_stroke || is_trap ||
             ((pix_x[0] ^ pix_y[0]) == attr_r[`ATTR_PARITY]);
    work_ok = !(attr_r[`ATTR_WORK] && is_quad) || pix_work_bit;
    if (code_r == `CMD_QUAD_MULTI) kind = render_attr_pkg::SRC_MULTI;
    else if (is_binary) kind = render_attr_pkg::SRC_BINARY;
    else if (is_work_stroke) kind = render_attr_pkg::SRC_WORK_VALUE;
    else if (is_trap) kind = render_attr_pkg::SRC_WORK_TOGGLE;
    else if (is_quad || is_stroke) kind = render_attr_pkg::SRC_COLOUR;
    else kind = render_attr_pkg::SRC_NONE;
    colour_odd_nxt = colour_odd_r;
    src_ok = 1'b1;
    colour_nxt = fg_colour_r;
    case (kind)
      render_attr_pkg::SRC_MULTI: begin
        colour_nxt = pix_src_data;
        colour_odd_nxt = pix_src_data_odd;
        src_ok = !(attr_r[`ATTR_TRANSPARENT] &&
                   (pix_src_data == 16'h0000));
      end
      render_attr_pkg::SRC_BINARY: begin
        colour_nxt = pix_src_bit ? fg_colour_r : bg_colour_r;
        src_ok = pix_src_bit || !attr_r[`ATTR_TRANSPARENT];
      end
      render_attr_pkg::SRC_WORK_VALUE:
        colour_nxt = {15'h0000, attr_r[`ATTR_PARITY]};
      render_attr_pkg::SRC_WORK_TOGGLE: colour_nxt = 16'h0001;
      render_attr_pkg::SRC_COLOUR: colour_odd_nxt = fg_colour_r;
      default: src_ok = 1'b0;
    endcase
    out_valid_nxt = take ? 1'b1 : (out_ready ? 1'b0 : out_valid_r);
    write_nxt = write_r;
    x_nxt = x_r;
    y_nxt = y_r;
    to_work_nxt = to_work_r;
    if (!take) colour_nxt = colour_r;
    if (!take) colour_odd_nxt = colour_odd_r;
    if (take) begin
      x_nxt = pix_x;
      y_nxt = pix_y;
      to_work_nxt = is_work_stroke || is_trap;
      if (two_pixel_mode)
        write_nxt = {user_region_select_ok_odd, user_region_select_ok};
      else
        write_nxt = {1'b0, user_region_select_ok && net_ok && work_ok && src_ok};
    end
    wr_count_nxt = count_clear ? 16'h0000 : wr_count_r;
    skip_count_nxt = count_clear ? 16'h0000 : skip_count_r;
    if (take && (write_nxt != 2'h0)) wr_count_nxt = wr_count_nxt + 16'h0001;
    if (take && (write_nxt == 2'h0))
      skip_count_nxt = skip_count_nxt + 16'h0001;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      out_valid_r <= 1'b0;
      write_r <= 2'h0;
      to_work_r <= 1'b0;
      x_r <= '0;
      y_r <= '0;
      colour_r <= 16'h0000;
      colour_odd_r <= 16'h0000;
      wr_count_r <= 16'h0000;
      skip_count_r <= 16'h0000;
    end else begin
      out_valid_r <= out_valid_nxt;
      write_r <= write_nxt;
      to_work_r <= to_work_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
      colour_r <= colour_nxt;
      colour_odd_r <= colour_odd_nxt;
      wr_count_r <= wr_count_nxt;
      skip_count_r <= skip_count_nxt;
    end
  end

  assign out_valid = out_valid_r;
  assign out_write = write_r;
  assign out_to_work = to_work_r;
  assign out_x = x_r;
  assign out_y = y_r;
  assign out_colour = colour_r;
  assign out_colour_odd = colour_odd_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence bin_zero_taken;
    take && is_binary && !pix_src_bit && !two_pixel_mode;
  endsequence

  sequence plain_quad_taken;
    take && (code_r == `CMD_QUAD_SOLID) && !attr_r[`ATTR_NET] &&
    !attr_r[`ATTR_WORK] && !two_pixel_mode;
  endsequence

  trans_skip_a: assert property (
    bin_zero_taken ##0 attr_r[`ATTR_TRANSPARENT] |=> out_write == 2'h0)
    else $error("transparent zero source bit was written");
  bg_colour_a: assert property (
    bin_zero_taken ##0 !attr_r[`ATTR_TRANSPARENT] |=>
    out_colour == $past(bg_colour_r))
    else $error("opaque zero source bit lacks background colour");
  multi_zero_a: assert property (
    take && (code_r == `CMD_QUAD_MULTI) && attr_r[`ATTR_TRANSPARENT] &&
    !two_pixel_mode && (pix_src_data == 16'h0000) |=> !out_write[0])
    else $error("all-zero multi-valued pixel was written");
  sys_user_region_select_a: assert property (
    take && !attr_r[`ATTR_USER_REGION] && !two_pixel_mode &&
    (pix_x > $signed(sys_max_x_r)) |=> out_write == 2'h0)
    else $error("pixel right of system region was written");
  user_user_region_select_a: assert property (
    plain_quad_taken ##0 attr_r[`ATTR_USER_REGION] &&
    pix_x == $signed(usr_max_x_r) && pix_y == $signed(usr_min_y_r) |=>
    out_write[0] && out_valid)
    else $error("pixel on user region corner was not written");
  net_parity_a: assert property (
    take && is_quad && attr_r[`ATTR_NET] && !two_pixel_mode &&
    ((pix_x[0] ^ pix_y[0]) != attr_r[`ATTR_PARITY]) |=> !out_write[0])
    else $error("net drawing wrote pixel of wrong parity");
  work_value_a: assert property (
    take && is_work_stroke |=>
    out_to_work && out_colour == {15'h0000, $past(attr_r[`ATTR_PARITY])})
    else $error("work stroke did not write parity value");
  work_mask_a: assert property (
    take && is_quad && attr_r[`ATTR_WORK] && !two_pixel_mode &&
    !pix_work_bit |=> !out_write[0])
    else $error("masked pixel written over zero work bit");
  bold_width_a: assert property (
    cmd_load && (cmd_code == `CMD_STROKE) &&
    (cmd_attr[3:0] == 4'hF) |=> line_width == 3'h5 ##1 $stable(line_width))
    else $error("full bold line width is not five");
  out_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_colour) &&
    $stable(out_write))
    else $error("output pixel changed while stalled");

endmodule

// File: rtl/render_attr_map.svh
// Constants for the rendering attribute pixel gate: bit positions,
// command codes, register offsets and reset values.
// Assumes it is included by its bare name from the package and the gate.
`ifndef RENDER_ATTR_MAP_SVH
`define RENDER_ATTR_MAP_SVH

// ----------------------------------------------------------------------
// Attribute word fields
// ----------------------------------------------------------------------
`define ATTR_W 12
`define ATTR_TRANSPARENT 10
`define ATTR_TILE 9
`define ATTR_USER_REGION 8
`define ATTR_NET 6
`define ATTR_PARITY 5
`define ATTR_TWO_PIXEL 4
`define ATTR_LINEAR 3
`define ATTR_HALF 1
`define ATTR_WORK 0
`define ATTR_THICK_UL 3
`define ATTR_DOUBLE_UL 2
`define ATTR_THICK_DR 1
`define ATTR_DOUBLE_DR 0

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define CMD_QUAD_MULTI 5'h00
`define CMD_QUAD_BINARY 5'h01
`define CMD_QUAD_SOLID 5'h02
`define CMD_TRAP_FILL 5'h08
`define CMD_REL_TRAP_FILL 5'h09
`define CMD_WORK_STROKE 5'h0A
`define CMD_REL_WORK_STROKE 5'h0B
`define CMD_STROKE 5'h0C
`define CMD_REL_STROKE 5'h0D
`define CMD_TEX_STROKE 5'h0E
`define CMD_REL_TEX_STROKE 5'h0F

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define REG_SYS_MIN 8'h00
`define REG_SYS_MAX 8'h04
`define REG_USR_MIN 8'h08
`define REG_USR_MAX 8'h0C
`define REG_BG_COLOUR 8'h10
`define REG_FG_COLOUR 8'h14
`define REG_STATUS 8'h18
`define REG_CONTROL 8'h1C
`define COORD_W 11
`define COORD_Y_LSB 16
`define MIN_RESET 11'h400
`define MAX_RESET 11'h3FF
`define COLOUR_RESET 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: rtl/render_attr_pkg.sv
// Types shared by the rendering attribute pixel gate.
// Assumes render_attr_map.svh is on the include path.
`include "render_attr_map.svh"

package render_attr_pkg;

  // ----------------------------------------------------------------------
  // Pixel source classes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_MULTI,
    SRC_BINARY,
    SRC_COLOUR,
    SRC_WORK_VALUE,
    SRC_WORK_TOGGLE
  } src_kind_t;

  typedef logic signed [`COORD_W-1:0] coord_t;

endpackage

// File: tb/cmd_host_model.sv
// Host-side model that builds commands and loads them into the gate.
// Assumes one request pulse from the bench on mclk for each command.
`timescale 1ns/1ps
module cmd_host_model (
  // Clock
  input wire logic mclk,
  // Bench request
  input wire logic h_req,
  input wire logic [4:0] h_code,
  input wire logic [11:0] h_attr,
  // Command load
  output logic cmd_load,
  output logic [4:0] cmd_code,
  output logic [11:0] cmd_attr
);
  // The bench builds attributes with unsupported bits already zero.
  always_ff @(posedge mclk) begin
    // Commands only: the model never touches graphics memory itself.
    cmd_load <= h_req;
    cmd_code <= h_code;
    // Half sampling is dropped when tile repeat is asked for too.
    cmd_attr <= h_attr & ~(h_attr[9] ? 12'h002 : 12'h000);
  end
endmodule

// File: tb/tb.sv
// Self-checking bench for the rendering attribute pixel gate.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, cmd_load, h_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, extra_up_left, extra_down_right;
  logic [1:0] out_write;
  logic [4:0] cmd_code, h_code;
  logic [11:0] cmd_attr, h_attr;
  logic tile_repeat_enable, half_sample_enable, half_sample_phase;
  logic linear_source_address, two_pixel_mode, pix_valid, pix_ready;
  logic pix_src_bit, pix_work_bit, out_valid, out_ready, out_to_work;
  logic [2:0] line_width;
  logic signed [10:0] pix_x, pix_y, out_x, out_y;
  logic [15:0] pix_src_data, pix_src_data_odd, out_colour, out_colour_odd;
  logic [15:0] r;
  logic [17:0] expq[$];
  logic [38:0] xyq[$];
  logic [38:0] e2;
  logic [21:0] mt[4] = '{{5'h00, 12'h208, 5'h12}, {5'h01, 12'h022, 5'h0C},
                         {5'h02, 12'h010, 5'h01}, {5'h0E, 12'h200, 5'h10}};
  localparam logic [15:0] bg_c = 16'h1234;
  localparam logic [15:0] fg_c = 16'hABCD;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  render_attribute_pixel_gate dut (.*);
  cmd_host_model host (.*);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [33:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    logic [1:0] got;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    @(negedge mclk);
    while (!s_axi_awready) @(negedge mclk);
    @(posedge mclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    @(negedge mclk);
    while (!s_axi_bvalid) @(negedge mclk);
    got = s_axi_bresp;
    @(posedge mclk);
    s_axi_bready <= 1'b0;
    chk(34'(got), 34'(e), "write response");
  endtask

  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    logic [33:0] got;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(negedge mclk);
    while (!s_axi_arready) @(negedge mclk);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    @(negedge mclk);
    while (!s_axi_rvalid) @(negedge mclk);
    got = {s_axi_rresp, s_axi_rdata};
    @(posedge mclk);
    s_axi_rready <= 1'b0;
    chk(got, e, "read");
  endtask

  // Waits for every expected pixel, then loads the next command.
  task automatic cmd(input logic [4:0] c, input logic [11:0] a);
    pix_valid <= 1'b0;
    while (expq.size() != 0) @(posedge mclk);
    $display("Test step finished at %0t", $time);
    h_code <= c;
    h_attr <= a;
    h_req <= 1'b1;
    @(posedge mclk);
    h_req <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic pix(input int x, y, input logic sb, input logic [15:0] sd,
                     input logic wb, w, input logic [15:0] c,
                     input logic tw = 1'b0, input logic w1 = 1'b0,
                     input logic [15:0] so = 16'h0000);
    expq.push_back({tw, w, c});
    xyq.push_back({w1, 11'(x), 11'(y), so});
    pix_src_data_odd <= so;
    pix_x <= 11'(x);
    pix_y <= 11'(y);
    pix_src_bit <= sb;
    pix_src_data <= sd;
    pix_work_bit <= wb;
    pix_valid <= 1'b1;
    @(negedge mclk);
    while (!pix_ready) @(negedge mclk);
    @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Clock, output stalls, monitor and timeout
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    out_ready <= ($urandom % 4) != 0;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
    if (reset_n && out_valid && out_ready) begin
      if (expq.size() == 0) chk(34'h0, 34'h1, "extra pixel");
      else begin
        chk(34'({out_to_work, out_write[0], out_colour}),
            34'(expq.pop_front()), "pixel");
        e2 = xyq.pop_front();
        chk(34'({out_write[1], out_x, out_y}), 34'(e2[38:16]), "place");
        if (e2[38]) chk(34'(out_colour_odd), 34'(e2[15:0]), "odd");
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h73335343));
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, h_req, pix_valid, out_ready} = 5'h01;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hF;
    {h_code, h_attr, pix_x, pix_y, pix_src_bit, pix_work_bit} = 41'h0;
    {pix_src_data, pix_src_data_odd} = 32'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    axr(8'h00, 34'h004000400);
    axw(8'h04, 32'h00280028, 2'h0);
    axw(8'h08, 32'h00140014, 2'h0);
    axw(8'h0C, 32'h001E001E, 2'h0);
    axw(8'h10, 32'(bg_c), 2'h0);
    axw(8'h14, 32'(fg_c), 2'h0);
    axw(8'h00, 32'h00000000, 2'h0);
    axw(8'h20, 32'h00000001, 2'h2);
    axr(8'h04, 34'h000280028);
    axr(8'h24, 34'h200000000);
    for (int i = 0; i < 16; i++) begin
      cmd(5'h0C, 12'(i));
      chk(34'(line_width), 34'(1 + (i[3] ? 1 + i[2] : 0) +
          (i[1] ? 1 + i[0] : 0)), "width");
      chk(34'({extra_up_left, extra_down_right}),
          34'({2'(i[3] ? 1 + i[2] : 0), 2'(i[1] ? 1 + i[0] : 0)}),
          "extras");
    end
    foreach (mt[k]) begin
      cmd(mt[k][21:17], mt[k][16:5]);
      chk(34'({tile_repeat_enable, half_sample_enable, half_sample_phase,
               linear_source_address, two_pixel_mode}),
          34'(mt[k][4:0]), "mode");
    end
    cmd(5'h01, 12'h000);
    pix(5, 5, 0, 0, 0, 1, bg_c);
    pix(5, 5, 1, 0, 0, 1, fg_c);
    cmd(5'h01, 12'h400);
    pix(5, 5, 0, 0, 0, 0, bg_c);
    pix(5, 5, 1, 0, 0, 1, fg_c);
    cmd(5'h00, 12'h400);
    r = 16'($urandom) | 16'h0001;
    pix(6, 6, 0, 0, 0, 0, 0);
    pix(6, 6, 0, r, 0, 1, r);
    cmd(5'h00, 12'h110);
    pix(28, 25, 0, r, 0, 1, r, 0, 1, ~r);
    pix(30, 25, 0, r, 0, 1, r, 0, 0, ~r);
    cmd(5'h02, 12'h000);
    pix(40, 40, 0, 0, 0, 1, fg_c);
    pix(41, 40, 0, 0, 0, 0, fg_c);
    pix(0, 0, 0, 0, 0, 1, fg_c);
    pix(0, -1, 0, 0, 0, 0, fg_c);
    pix(5, 41, 0, 0, 0, 0, fg_c);
    cmd(5'h02, 12'h100);
    pix(20, 30, 0, 0, 0, 1, fg_c);
    pix(30, 20, 0, 0, 0, 1, fg_c);
    pix(5, 5, 0, 0, 0, 0, fg_c);
    pix(30, 31, 0, 0, 0, 0, fg_c);
    cmd(5'h02, 12'h040);
    pix(2, 4, 0, 0, 0, 1, fg_c);
    pix(3, 4, 0, 0, 0, 0, fg_c);
    cmd(5'h02, 12'h060);
    pix(3, 4, 0, 0, 0, 1, fg_c);
    cmd(5'h02, 12'h001);
    pix(4, 4, 0, 0, 0, 0, fg_c);
    pix(4, 4, 0, 0, 1, 1, fg_c);
    cmd(5'h0E, 12'h001);
    pix(4, 4, 1, fg_c, 0, 1, fg_c);
    cmd(5'h0A, 12'h020);
    pix(5, 5, 0, 0, 0, 1, 16'h0001, 1);
    cmd(5'h0B, 12'h000);
    pix(5, 5, 0, 0, 0, 1, 16'h0000, 1);
    cmd(5'h02, 12'h000);
    print_verdict();
  end
endmodule
